//--- src/spas_top.sv
// stimulus port user access mask and port group select register bank with AXI4-Lite slave
// Notes on behaviour
// - user access mask is written only by privileged or debugger accesses.
// - each mask bit covers ports 8n..8n+7; one blocks user-mode accesses there.
// - mask width follows port count, four bits for 32 ports; upper bits read zero.
// - masking covers up to 256 ports, basic and extended alike.
// - with 32 or fewer ports the group select register is reserved.
// - group select field sits in bits 31:20; bits 19:2 reserved.
// - scope bits 1:0 mean none, trigger only, reserved, both; reset none.
// - scope none ignores groups; enable bit i serves ports i plus multiples of 32.
// - scopes trigger-only and both restrict affected enables to the selected groups; reserved restricts nothing.
// - low zeros of the field mask, the next one delimits, upper bits name groups.
// - field lsb one selects exactly the single group named by upper bits.
// - only top field bit set selects all ports, same as scope none.
// - a write to a disabled port never triggers.
// - port enable holds one bit per port modulo 32, one enables, resets to zero.
// - trigger enable bit makes writes to the enabled port trigger.
// - scope trigger-only keeps enables on all groups, triggers only in selected ones.
//
// Local design decisions: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none

module spas_top #(
  parameter int unsigned NUM_PORTS = 256,
  parameter int unsigned PW        = (NUM_PORTS > 1) ? $clog2(NUM_PORTS) : 1
) (
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  input  wire logic                          debugger_access,
  input  wire logic [spas_pkg::ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic [2:0]                    s_axi_awprot,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [spas_pkg::ADDR_W-1:0]   s_axi_araddr,
  input  wire logic [2:0]                    s_axi_arprot,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  input  wire logic                          stim_valid,
  input  wire logic [PW-1:0]                 stim_port,
  input  wire logic                          stim_user,
  output logic                               stim_accept,
  output logic                               stim_trigger,
  output logic                               stim_blocked
);

  localparam int unsigned NGROUPS   = (NUM_PORTS + spas_pkg::PORTS_PER_GROUP - 1) / spas_pkg::PORTS_PER_GROUP;
  localparam int unsigned MASK_W    = (NUM_PORTS + spas_pkg::PORTS_PER_BLOCK - 1) / spas_pkg::PORTS_PER_BLOCK;
  localparam int unsigned EN_W      = (NUM_PORTS < 32) ? NUM_PORTS : 32;
  localparam logic        HAS_GROUP = (NUM_PORTS > spas_pkg::PORTS_PER_GROUP);

  // ---------------- bus slave state ----------------
  logic                        aw_got_r;
  logic                        w_got_r;
  logic [spas_pkg::ADDR_W-1:0] waddr_r;
  logic                        wpriv_r;
  logic [31:0]                 wdata_r;
  logic [3:0]                  wstrb_r;
  logic                        bvalid_r;
  logic [1:0]                  bresp_r;
  logic                        rvalid_r;
  logic [31:0]                 rdata_r;
  logic [1:0]                  rresp_r;
  logic                        wr_do;

  // ---------------- register state ----------------
  logic [MASK_W-1:0]           user_block_bits_r;
  logic [11:0]                 group_select_field_r;
  logic [1:0]                  group_select_scope_r;
  logic [EN_W-1:0]             port_enable_bits_r;
  logic [EN_W-1:0]             trigger_enable_bits_r;
  logic [31:0]                 rd_nxt;
  logic [1:0]                  rresp_nxt;
  logic                        wr_hit;

  logic [NGROUPS-1:0]          group_sel;
  logic [NUM_PORTS-1:0]        eff_enable;
  logic [NUM_PORTS-1:0]        eff_trigger;

  // ---------------- write channel ----------------
  assign s_axi_awready = !aw_got_r && !bvalid_r;
  assign s_axi_wready  = !w_got_r && !bvalid_r;
  assign wr_do         = aw_got_r && w_got_r && !bvalid_r;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_r <= 1'b0;
      waddr_r  <= '0;
      wpriv_r  <= 1'b0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_got_r <= 1'b1;
      waddr_r  <= s_axi_awaddr;
      wpriv_r  <= s_axi_awprot[spas_pkg::PROT_PRIV_BIT] || debugger_access;
    end
    else if (wr_do)
    begin
      aw_got_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_got_r <= 1'b0;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_got_r <= 1'b1;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end
    else if (wr_do)
    begin
      w_got_r <= 1'b0;
    end
  end

  always_comb
  begin
    wr_hit = 1'b1;
    case (waddr_r & ~spas_pkg::ADDR_W'(3))
      spas_pkg::OFS_USER_MASK: wr_hit = 1'b1;
      spas_pkg::OFS_GROUP_CFG: wr_hit = 1'b1;
      spas_pkg::OFS_PORT_EN:   wr_hit = 1'b1;
      spas_pkg::OFS_TRIG_EN:   wr_hit = 1'b1;
      default:                 wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_r <= 1'b0;
      bresp_r  <= spas_pkg::RESP_OKAY;
    end
    else if (wr_do)
    begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_hit ? spas_pkg::RESP_OKAY : spas_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
    begin
      bvalid_r <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp  = bresp_r;

  // ---------------- registers ----------------
  // user-mode writes to the mask complete with OKAY but change nothing
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      user_block_bits_r <= spas_pkg::MASK_RST[MASK_W-1:0];
    end
    else if (wr_do && wpriv_r && (waddr_r & ~spas_pkg::ADDR_W'(3)) == spas_pkg::OFS_USER_MASK)
    begin
      for (int i = 0; i < MASK_W; i++)
      begin
        if (wstrb_r[i/8])
        begin
          user_block_bits_r[i] <= wdata_r[i];
        end
      end
    end
  end

  // group register exists only beyond 32 ports
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      group_select_field_r <= spas_pkg::GSEL_RST;
      group_select_scope_r <= spas_pkg::SCOPE_RST;
    end
    else if (HAS_GROUP && wr_do && (waddr_r & ~spas_pkg::ADDR_W'(3)) == spas_pkg::OFS_GROUP_CFG)
    begin
      if (wstrb_r[3] && wstrb_r[2])
      begin
        group_select_field_r <= wdata_r[spas_pkg::GSEL_LSB +: spas_pkg::GSEL_W];
      end
      if (wstrb_r[0])
      begin
        group_select_scope_r <= wdata_r[spas_pkg::SCOPE_LSB +: spas_pkg::SCOPE_W];
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      port_enable_bits_r    <= spas_pkg::EN_RST[EN_W-1:0];
      trigger_enable_bits_r <= spas_pkg::EN_RST[EN_W-1:0];
    end
    else if (wr_do && (waddr_r & ~spas_pkg::ADDR_W'(3)) == spas_pkg::OFS_PORT_EN)
    begin
      for (int i = 0; i < EN_W; i++)
      begin
        if (wstrb_r[i/8])
        begin
          port_enable_bits_r[i] <= wdata_r[i];
        end
      end
    end
    else if (wr_do && (waddr_r & ~spas_pkg::ADDR_W'(3)) == spas_pkg::OFS_TRIG_EN)
    begin
      for (int i = 0; i < EN_W; i++)
      begin
        if (wstrb_r[i/8])
        begin
          trigger_enable_bits_r[i] <= wdata_r[i];
        end
      end
    end
  end

  // ---------------- read channel ----------------
  assign s_axi_arready = !rvalid_r;

  always_comb
  begin
    rd_nxt    = 32'h00000000;
    rresp_nxt = spas_pkg::RESP_OKAY;
    case (s_axi_araddr & ~spas_pkg::ADDR_W'(3))
      spas_pkg::OFS_USER_MASK: rd_nxt[MASK_W-1:0] = user_block_bits_r;
      spas_pkg::OFS_GROUP_CFG:
      begin
        if (HAS_GROUP)
        begin
          rd_nxt[spas_pkg::GSEL_LSB +: spas_pkg::GSEL_W]   = group_select_field_r;
          rd_nxt[spas_pkg::SCOPE_LSB +: spas_pkg::SCOPE_W] = group_select_scope_r;
        end
      end
      spas_pkg::OFS_PORT_EN:   rd_nxt[EN_W-1:0] = port_enable_bits_r;
      spas_pkg::OFS_TRIG_EN:   rd_nxt[EN_W-1:0] = trigger_enable_bits_r;
      default:                 rresp_nxt = spas_pkg::RESP_SLVERR;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h00000000;
      rresp_r  <= spas_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_nxt;
      rresp_r  <= rresp_nxt;
    end
    else if (s_axi_rready)
    begin
      rvalid_r <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata  = rdata_r;
  assign s_axi_rresp  = rresp_r;

  // ---------------- group selection and port mapping ----------------
  spas_group_decode #(
    .NGROUPS            (NGROUPS)
  ) u_group_decode (
    .group_select_field (group_select_field_r),
    .group_sel          (group_sel)
  );

  spas_port_map #(
    .NUM_PORTS           (NUM_PORTS),
    .NGROUPS             (NGROUPS),
    .EN_W                (EN_W)
  ) u_port_map (
    .port_enable_bits    (port_enable_bits_r),
    .trigger_enable_bits (trigger_enable_bits_r),
    .group_sel           (group_sel),
    .group_select_scope  (group_select_scope_r),
    .eff_enable          (eff_enable),
    .eff_trigger         (eff_trigger)
  );

  // ---------------- stimulus write qualification ----------------
  logic user_masked;
  logic accept_nxt;

  assign user_masked = stim_user && user_block_bits_r[32'(stim_port) / spas_pkg::PORTS_PER_BLOCK];
  assign accept_nxt  = stim_valid && eff_enable[stim_port] && !user_masked;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stim_accept  <= 1'b0;
      stim_trigger <= 1'b0;
      stim_blocked <= 1'b0;
    end
    else
    begin
      stim_accept  <= accept_nxt;
      stim_trigger <= accept_nxt && eff_trigger[stim_port];
      stim_blocked <= stim_valid && user_masked;
    end
  end

  // ---------------- assertions ----------------
  sequence s_write_pending;
    aw_got_r && w_got_r && !bvalid_r;
  endsequence

  sequence s_mask_write(logic priv);
    s_write_pending ##0 (wpriv_r == priv) &&
      ((waddr_r & ~spas_pkg::ADDR_W'(3)) == spas_pkg::OFS_USER_MASK);
  endsequence

  property p_user_mask_write;
    @(posedge aclk) disable iff (!aresetn)
    s_mask_write(1'b0) |=> $stable(user_block_bits_r) && s_axi_bvalid;
  endproperty
  a_user_mask_write: assert property (p_user_mask_write) else $error("user write changed mask");

  property p_priv_mask_write;
    @(posedge aclk) disable iff (!aresetn)
    s_mask_write(1'b1) ##0 (wstrb_r == 4'hF) |=> user_block_bits_r == $past(wdata_r[MASK_W-1:0]);
  endproperty
  a_priv_mask_write: assert property (p_priv_mask_write) else $error("privileged mask write lost");

  property p_mask_read_high_zero;
    @(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready && ((s_axi_araddr & ~spas_pkg::ADDR_W'(3)) == spas_pkg::OFS_USER_MASK)
      |=> s_axi_rvalid && ((s_axi_rdata >> MASK_W) == 32'h00000000);
  endproperty
  a_mask_read_high_zero: assert property (p_mask_read_high_zero) else $error("mask upper bits not zero");

  property p_user_block;
    @(posedge aclk) disable iff (!aresetn)
    stim_valid && stim_user && user_block_bits_r[32'(stim_port) / spas_pkg::PORTS_PER_BLOCK]
      |=> stim_blocked && !stim_accept && !stim_trigger;
  endproperty
  a_user_block: assert property (p_user_block) else $error("masked user access accepted");

  property p_trigger_needs_enable;
    @(posedge aclk) disable iff (!aresetn)
    stim_trigger |-> stim_accept && $past(eff_enable[stim_port]);
  endproperty
  a_trigger_needs_enable: assert property (p_trigger_needs_enable) else $error("trigger from disabled port");

  property p_scope_none_alias;
    @(posedge aclk) disable iff (!aresetn)
    stim_valid && !stim_user && group_select_scope_r == spas_pkg::SCOPE_NONE
      |=> stim_accept == $past(port_enable_bits_r[stim_port % EN_W]);
  endproperty
  a_scope_none_alias: assert property (p_scope_none_alias) else $error("scope none enable mismatch");

  property p_trig_only_scope;
    @(posedge aclk) disable iff (!aresetn)
    stim_valid && !stim_user && group_select_scope_r == spas_pkg::SCOPE_TRIG
      |=> (stim_accept == $past(port_enable_bits_r[stim_port % EN_W])) &&
          (!stim_trigger || $past(group_sel[32'(stim_port) / spas_pkg::PORTS_PER_GROUP]));
  endproperty
  a_trig_only_scope: assert property (p_trig_only_scope) else $error("trigger outside selected group");

  property p_single_group;
    @(posedge aclk) disable iff (!aresetn)
    group_select_field_r[0] |-> group_sel == NGROUPS'(({{NGROUPS{1'b0}}, 1'b1}) << group_select_field_r[11:1]);
  endproperty
  a_single_group: assert property (p_single_group) else $error("single group decode wrong");

  property p_top_bit_all;
    @(posedge aclk) disable iff (!aresetn)
    group_select_field_r == 12'h800 |-> &group_sel;
  endproperty
  a_top_bit_all: assert property (p_top_bit_all) else $error("top bit does not select all");

  property p_no_group_reg;
    @(posedge aclk) disable iff (!aresetn)
    !HAS_GROUP |-> group_select_scope_r == spas_pkg::SCOPE_NONE && group_select_field_r == spas_pkg::GSEL_RST;
  endproperty
  a_no_group_reg: assert property (p_no_group_reg) else $error("absent group register changed");

endmodule // spas_top

`default_nettype wire

//--- shared/spas_pkg.sv
// shared constants for the stimulus port access and group select block
`default_nettype none

package spas_pkg;

  // register byte offsets on the AXI4-Lite slave
  localparam int unsigned  ADDR_W          = 8;
  localparam logic [7:0]   OFS_USER_MASK   = 8'h00;
  localparam logic [7:0]   OFS_GROUP_CFG   = 8'h04;
  localparam logic [7:0]   OFS_PORT_EN     = 8'h08;
  localparam logic [7:0]   OFS_TRIG_EN     = 8'h0C;

  // group select configuration layout
  localparam int unsigned  GSEL_LSB        = 20;
  localparam int unsigned  GSEL_W          = 12;
  localparam int unsigned  SCOPE_LSB       = 0;
  localparam int unsigned  SCOPE_W         = 2;

  // group select scope encodings
  localparam logic [1:0]   SCOPE_NONE      = 2'h0;
  localparam logic [1:0]   SCOPE_TRIG      = 2'h1;
  localparam logic [1:0]   SCOPE_RSVD      = 2'h2;
  localparam logic [1:0]   SCOPE_BOTH      = 2'h3;

  // reset values
  localparam logic [11:0]  GSEL_RST        = 12'h000;
  localparam logic [1:0]   SCOPE_RST       = 2'h0;
  localparam logic [31:0]  MASK_RST        = 32'h00000000;
  localparam logic [31:0]  EN_RST          = 32'h00000000;

  // port geometry
  localparam int unsigned  PORTS_PER_GROUP = 32;
  localparam int unsigned  PORTS_PER_BLOCK = 8;
  localparam int unsigned  MAX_PORTS       = 256;

  // bus answers
  localparam logic [1:0]   RESP_OKAY       = 2'h0;
  localparam logic [1:0]   RESP_SLVERR     = 2'h2;
  localparam int unsigned  PROT_PRIV_BIT   = 0;

endpackage

`default_nettype wire

//--- src/spas_group_decode.sv
// decodes the group select field into one select bit per group of 32 ports
`timescale 1ns/1ps
`default_nettype none

module spas_group_decode #(
  parameter int unsigned NGROUPS = 8
) (
  input  wire logic [11:0]        group_select_field,
  output logic      [NGROUPS-1:0] group_sel
);

  logic [3:0]  low_idx;
  logic        found;
  logic [4:0]  shift_up;
  logic [31:0] upper;

  // lowest one marks the end of the don't-care mask
  always_comb
  begin
    low_idx = 4'h0;
    found   = 1'b0;
    for (int i = 11; i >= 0; i--)
    begin
      if (group_select_field[i])
      begin
        low_idx = 4'(i);
        found   = 1'b1;
      end
    end
  end

  assign shift_up = {1'b0, low_idx} + 5'h01;
  assign upper    = {20'h00000, group_select_field} >> shift_up;

  // an all-zero field selects nothing
  for (genvar g = 0; g < NGROUPS; g++)
  begin : g_grp
    localparam logic [31:0] GIDX = 32'(g);
    assign group_sel[g] = found && ((GIDX >> low_idx) == upper);
  end

endmodule // spas_group_decode

`default_nettype wire

//--- src/spas_port_map.sv
// maps the 32 enable and trigger enable bits onto every port through the group selection
`timescale 1ns/1ps
`default_nettype none

module spas_port_map #(
  parameter int unsigned NUM_PORTS = 256,
  parameter int unsigned NGROUPS   = 8,
  parameter int unsigned EN_W      = 32
) (
  input  wire logic [EN_W-1:0]      port_enable_bits,
  input  wire logic [EN_W-1:0]      trigger_enable_bits,
  input  wire logic [NGROUPS-1:0]   group_sel,
  input  wire logic [1:0]           group_select_scope,
  output logic      [NUM_PORTS-1:0] eff_enable,
  output logic      [NUM_PORTS-1:0] eff_trigger
);

  logic sel_en;
  logic sel_trig;

  assign sel_en   = (group_select_scope == spas_pkg::SCOPE_BOTH);
  assign sel_trig = (group_select_scope == spas_pkg::SCOPE_BOTH) ||
                    (group_select_scope == spas_pkg::SCOPE_TRIG);

  for (genvar p = 0; p < NUM_PORTS; p++)
  begin : g_port
    localparam int unsigned B = p % spas_pkg::PORTS_PER_GROUP;
    localparam int unsigned G = p / spas_pkg::PORTS_PER_GROUP;
    // bit i serves port i plus any multiple of 32 unless groups restrict it
    assign eff_enable[p]  = port_enable_bits[B] & (!sel_en || group_sel[G]);
    // a port that is not enabled never triggers
    assign eff_trigger[p] = eff_enable[p] & trigger_enable_bits[B] &
                            (!sel_trig || group_sel[G]);
  end

endmodule // spas_port_map

`default_nettype wire

//--- verif/spas_top_bench.sv
// self-checking bench for the stimulus port access and group select block
`timescale 1ns/1ps
`default_nettype none

module spas_top_bench;
  localparam logic [7:0] A_UM = spas_pkg::OFS_USER_MASK;
  localparam logic [7:0] A_GC = spas_pkg::OFS_GROUP_CFG;
  localparam logic [7:0] A_PE = spas_pkg::OFS_PORT_EN;
  localparam logic [7:0] A_TE = spas_pkg::OFS_TRIG_EN;
  logic        aclk, aresetn, debugger_access;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, stim_port;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        stim_valid, stim_user, stim_accept, stim_trigger, stim_blocked;
  int          bad_count;
  int          samples_checked;

  spas_top i_spas_top (.aclk, .aresetn, .debugger_access, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .stim_valid, .stim_port, .stim_user, .stim_accept, .stim_trigger,
    .stim_blocked);

  initial
  begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  task automatic close_out;
    begin
      if (bad_count == 0 && samples_checked > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    begin
      samples_checked++;
      if (got !== exp)
      begin
        bad_count++;
        $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
      end
    end
  endtask

  task automatic step(inout int n);
    begin
      @(posedge aclk);
      n++;
      if (n > 50)
      begin
        bad_count++;
        $display("BAD %0t bus wait ran out", $time);
        close_out();
      end
    end
  endtask

  // write: both channels offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [2:0] p = 3'h1,
                    input logic [1:0] er = spas_pkg::RESP_OKAY);
    int n;
    bit ad;
    bit wd;
    begin
      n = 0;
      ad = 1'b0;
      wd = 1'b0;
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_awprot  <= p;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata   <= d;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do
      begin
        step(n);
        if (s_axi_awvalid && s_axi_awready)
        begin
          ad = 1'b1;
          s_axi_awvalid <= 1'b0;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
          wd = 1'b1;
          s_axi_wvalid <= 1'b0;
        end
      end while (!(ad && wd));
      while (s_axi_bvalid !== 1'b1)
        step(n);
      chk({30'h0, s_axi_bresp}, {30'h0, er}, "bresp");
      s_axi_bready <= 1'b0;
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er = spas_pkg::RESP_OKAY);
    int n;
    begin
      n = 0;
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do
      begin
        step(n);
        if (s_axi_arvalid && s_axi_arready)
          s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      chk(s_axi_rdata, ed, "rdata");
      chk({30'h0, s_axi_rresp}, {30'h0, er}, "rresp");
      s_axi_rready <= 1'b0;
    end
  endtask

  // one port write attempt; e is {accept, trigger, blocked} one cycle later
  task automatic st(input logic [7:0] port, input logic u, input logic [2:0] e);
    begin
      @(posedge aclk);
      stim_port  <= port;
      stim_user  <= u;
      stim_valid <= 1'b1;
      @(posedge aclk);
      stim_valid <= 1'b0;
      #1;
      chk({29'h0, stim_accept, stim_trigger, stim_blocked}, {29'h0, e}, "stim");
    end
  endtask

  task automatic t_reset;
    begin
      rd(A_UM, 32'h0);
      rd(A_GC, 32'h0);
      rd(A_PE, 32'h0);
      rd(A_TE, 32'h0);
      st(8'd0, 1'b0, 3'b000);
    end
  endtask

  task automatic t_mask;
    begin
      wr(A_PE, 32'hFFFFFFFF);
      wr(A_UM, 32'h00000002, 3'h0);
      rd(A_UM, 32'h0);
      wr(A_UM, 32'h00000002);
      rd(A_UM, 32'h00000002);
      st(8'd8, 1'b1, 3'b001);
      st(8'd15, 1'b1, 3'b001);
      st(8'd16, 1'b1, 3'b100);
      st(8'd8, 1'b0, 3'b100);
      debugger_access <= 1'b1;
      wr(A_UM, 32'h80000000, 3'h0);
      debugger_access <= 1'b0;
      rd(A_UM, 32'h80000000);
      st(8'd255, 1'b1, 3'b001);
      st(8'd247, 1'b1, 3'b100);
      wr(A_UM, 32'h0);
    end
  endtask

  task automatic t_scope;
    begin
      wr(A_PE, 32'h1);
      wr(A_TE, 32'h1);
      wr(A_GC, 32'h00300000);
      st(8'd0, 1'b0, 3'b110);
      st(8'd32, 1'b0, 3'b110);
      st(8'd224, 1'b0, 3'b110);
      st(8'd5, 1'b0, 3'b000);
      wr(A_GC, 32'h00300001);
      rd(A_GC, 32'h00300001);
      st(8'd0, 1'b0, 3'b100);
      st(8'd32, 1'b0, 3'b110);
      st(8'd64, 1'b0, 3'b100);
      wr(A_GC, 32'h00300003);
      st(8'd32, 1'b0, 3'b110);
      st(8'd0, 1'b0, 3'b000);
      wr(A_GC, 32'h00600003);
      st(8'd64, 1'b0, 3'b110);
      st(8'd96, 1'b0, 3'b110);
      st(8'd32, 1'b0, 3'b000);
      st(8'd128, 1'b0, 3'b000);
      wr(A_GC, 32'h80000003);
      st(8'd0, 1'b0, 3'b110);
      st(8'd224, 1'b0, 3'b110);
      wr(A_GC, 32'h801FFFFF);
      rd(A_GC, 32'h80100003);
      wr(A_GC, 32'h00800003);
      st(8'd224, 1'b0, 3'b110);
      wr(A_GC, 32'h00300002);
      rd(A_GC, 32'h00300002);
      st(8'd64, 1'b0, 3'b110);
      wr(A_GC, 32'h0);
    end
  endtask

  task automatic t_unmapped;
    begin
      wr(8'h10, 32'h5A5A5A5A, 3'h1, spas_pkg::RESP_SLVERR);
      rd(8'h10, 32'h0, spas_pkg::RESP_SLVERR);
      rd(A_UM, 32'h0);
    end
  endtask

  // reset in mid-run after registers were loaded
  task automatic t_rereset;
    begin
      wr(A_UM, 32'h0000000F);
      wr(A_PE, 32'h00000001);
      wr(A_GC, 32'h00300003);
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rd(A_UM, 32'h0);
      rd(A_GC, 32'h0);
      rd(A_PE, 32'h0);
      st(8'd0, 1'b0, 3'b000);
    end
  endtask

  initial
  begin
    bad_count = 0;
    samples_checked = 0;
    aresetn = 1'b0;
    debugger_access = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_awprot = 3'h0;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arprot = 3'h1;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    stim_valid = 1'b0;
    stim_port = 8'h00;
    stim_user = 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_mask();
    t_scope();
    t_unmapped();
    t_rereset();
    close_out();
  end
endmodule // spas_top_bench

`default_nettype wire
